// File: crtc_pkg.sv
package crtc_pkg;
    // index/data port selection
    localparam logic PORT_INDEX = 1'b0;
    localparam logic PORT_DATA = 1'b1;
    // register indices
    localparam logic [7:0] IDX_UNDERLINE_ROW_ADDR_MODE = 8'h14;
    localparam logic [7:0] IDX_VBLANK_START = 8'h15;
    localparam logic [7:0] IDX_VBLANK_END = 8'h16;
    localparam logic [7:0] IDX_CRT_MODE_CONTROL = 8'h17;
    localparam logic [7:0] IDX_SPLIT_LINE_COMPARE = 8'h18;
    localparam logic [7:0] IDX_CPU_LATCH_READBACK = 8'h22;
    localparam logic [7:0] IDX_ATTR_INDEX_READBACK = 8'h24;
    localparam logic [7:0] IDX_ATTR_INDEX_READBACK_ALT = 8'h26;
    // underline_row_addr_mode fields
    localparam int UL_LOC_LSB = 0;
    localparam int UL_LOC_W = 5;
    localparam int UL_COUNT_BY_FOUR = 5;
    localparam int UL_DOUBLEWORD_SELECT = 6;
    localparam logic [7:0] UL_RD_MASK = 8'h7F;
    // crt_mode_control fields
    localparam int MC_BANK_TWO_SELECT = 0;
    localparam int MC_BANK_FOUR_SELECT = 1;
    localparam int MC_VERTICAL_DOUBLE = 2;
    localparam int MC_WORD_MODE_COUNT = 3;
    localparam int MC_ADDRESS_WRAP_SELECT = 5;
    localparam int MC_BYTE_MODE = 6;
    localparam int MC_RETRACE_ENABLE = 7;
    localparam logic [7:0] MC_RD_MASK = 8'hEF;
    localparam logic [7:0] MC_RESET = 8'h00;
    // other reset values (power-on undefined, zero chosen)
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    // address path
    localparam int ADDR_W = 16;
    localparam int VCOUNT_W = 11;
    localparam int ROW_W = 5;
    localparam int OFFSET_W = 10;
    // row pitch multipliers as shift amounts (x2, x4, x8)
    localparam int PITCH_SHIFT_WORD = 1;
    localparam int PITCH_SHIFT_DWORD = 2;
    localparam int PITCH_SHIFT_QWORD = 3;
    // memory address counter step periods in character clocks, vertical divider in retrace clocks
    localparam int STEP_DIV_WORD = 2;
    localparam int STEP_DIV_FOUR = 4;
    localparam int VT_DIV_DOUBLE = 2;
endpackage

// File: pulse_divider.sv
`timescale 1ns/1ps
module pulse_divider #(
    parameter int DIV = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic clear,
    input wire logic tick_in,
    // divided tick
    output logic tick_out
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count_q;

    // clear realigns the phase at a line start
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (clear) begin
            count_q <= '0;
        end else if (tick_in) begin
            count_q <= (count_q == LAST) ? '0 : count_q + CW'(1);
        end
    end

    assign tick_out = tick_in && (count_q == LAST);
endmodule

// File: crtc_vertical_addr_control.sv
`timescale 1ns/1ps
// Operation
// - underline on row scan line equal to five-bit underline field plus one
// - count-by-four steps address counter every four character clocks, else word-mode rule
// - doubleword select makes display addresses doubleword addresses, else byte or word
// - vertical blank begins one line past eleven-bit start value with extension bits
// - vertical blank ends when scan line low eight bits match end value
// - bank-two select low puts row scan bit 0 on address bit 13 during display
// - bank-four select low puts row scan bit 1 on address bit 14 during display
// - vertical counter steps on retrace clock, or half of it when vertical double set
// - word-mode count halves address counter clock; byte-mode low selects word addressing
// - word mode puts counter bit 13 on output bit 0, or bit 15 with wrap set
// - byte-mode low shifts counter up one, counter bit 13 or 15 to output bit 0
// - retrace enable low holds both retrace pulses inactive, nothing else reset
// - scan line equal to line compare clears address counter, rows then advance by pitch
// - latch readback returns graphics latch chosen by two-bit read plane select
// - attribute index readback answers at both of its two indices identically
// - attribute readback packs index, video enable, zero, inverted address flip-flop
// - registers reached through an indexed port: select index, then access data
// - row start advances by line width times two, four or eight by mode
module crtc_vertical_addr_control #(
    parameter int AW = crtc_pkg::ADDR_W,
    parameter int VW = crtc_pkg::VCOUNT_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // indexed host port
    input wire logic io_sel,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // timing strobes from the character and horizontal logic
    input wire logic char_clk_en,
    input wire logic hretrace_en,
    input wire logic h_display,
    input wire logic hsync_in,
    input wire logic vsync_in,
    // vertical geometry and extension fields held elsewhere
    input wire logic [VW-1:0] vertical_total,
    input wire logic [VW-1:0] vertical_display_end,
    input wire logic [crtc_pkg::ROW_W-1:0] max_scan_line,
    input wire logic [2:0] vblank_start_ext,
    input wire logic [2:0] line_compare_ext,
    input wire logic [crtc_pkg::OFFSET_W-1:0] logical_line_width,
    input wire logic quadword_select,
    input wire logic [AW-1:0] display_start_addr,
    // graphics and attribute controller state for readback
    input wire logic [31:0] gc_cpu_latch,
    input wire logic [1:0] read_plane_select,
    input wire logic [4:0] attr_index,
    input wire logic video_display_enable,
    input wire logic attr_address_flipflop,
    // display outputs
    output logic [AW-1:0] mem_addr,
    output logic underline,
    output logic vblank,
    output logic hsync_out,
    output logic vsync_out
);
    logic [7:0] index_q;
    logic [7:0] ul_mode_q;
    logic [7:0] vbs_q;
    logic [7:0] vbe_q;
    logic [7:0] mode_q;
    logic [7:0] lcmp_q;
    logic [7:0] rdata_d;
    logic [VW-1:0] scan_q;
    logic [crtc_pkg::ROW_W-1:0] row_q;
    logic [AW-1:0] ma_q;
    logic [AW-1:0] row_start_q;
    logic [AW-1:0] addr_d;
    logic [AW-1:0] pitch;
    logic [VW-1:0] vbs_full;
    logic [VW-1:0] lcmp_full;
    logic [VW-1:0] scan_next;
    logic data_wr;
    logic frame_end;
    logic row_end;
    logic split_hit;
    logic v_active;
    logic line_tick;
    logic line_tick_half;
    logic step_half;
    logic step_four;
    logic ma_step;

    function automatic logic is_attr_readback(input logic [7:0] idx);
        is_attr_readback = (idx == crtc_pkg::IDX_ATTR_INDEX_READBACK) ||
            (idx == crtc_pkg::IDX_ATTR_INDEX_READBACK_ALT);
    endfunction

    // host port: index write, then data access
    assign data_wr = io_wr && (io_sel == crtc_pkg::PORT_DATA);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            index_q <= crtc_pkg::INDEX_RESET;
        end else if (io_wr && (io_sel == crtc_pkg::PORT_INDEX)) begin
            index_q <= io_wdata;
        end
    end

    // readback registers take no writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ul_mode_q <= crtc_pkg::REG_RESET;
            vbs_q <= crtc_pkg::REG_RESET;
            vbe_q <= crtc_pkg::REG_RESET;
            mode_q <= crtc_pkg::MC_RESET;
            lcmp_q <= crtc_pkg::REG_RESET;
        end else if (data_wr) begin
            if (index_q == crtc_pkg::IDX_UNDERLINE_ROW_ADDR_MODE) begin
                ul_mode_q <= io_wdata & crtc_pkg::UL_RD_MASK;
            end else if (index_q == crtc_pkg::IDX_VBLANK_START) begin
                vbs_q <= io_wdata;
            end else if (index_q == crtc_pkg::IDX_VBLANK_END) begin
                vbe_q <= io_wdata;
            end else if (index_q == crtc_pkg::IDX_CRT_MODE_CONTROL) begin
                mode_q <= io_wdata & crtc_pkg::MC_RD_MASK;
            end else if (index_q == crtc_pkg::IDX_SPLIT_LINE_COMPARE) begin
                lcmp_q <= io_wdata;
            end
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (io_sel == crtc_pkg::PORT_INDEX) begin
            rdata_d = index_q;
        end else if (index_q == crtc_pkg::IDX_UNDERLINE_ROW_ADDR_MODE) begin
            rdata_d = ul_mode_q & crtc_pkg::UL_RD_MASK;
        end else if (index_q == crtc_pkg::IDX_VBLANK_START) begin
            rdata_d = vbs_q;
        end else if (index_q == crtc_pkg::IDX_VBLANK_END) begin
            rdata_d = vbe_q;
        end else if (index_q == crtc_pkg::IDX_CRT_MODE_CONTROL) begin
            rdata_d = mode_q & crtc_pkg::MC_RD_MASK;
        end else if (index_q == crtc_pkg::IDX_SPLIT_LINE_COMPARE) begin
            rdata_d = lcmp_q;
        end else if (index_q == crtc_pkg::IDX_CPU_LATCH_READBACK) begin
            rdata_d = gc_cpu_latch[read_plane_select*8 +: 8];
        end else if (is_attr_readback(index_q)) begin
            rdata_d = {~attr_address_flipflop, 1'b0, video_display_enable,
                attr_index};
        end
    end

    // read data held from a register so it stays steady after the strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            io_rdata <= rdata_d;
        end
    end

    // vertical timing clock: retrace strobe, optionally halved
    pulse_divider #(
        .DIV(crtc_pkg::VT_DIV_DOUBLE)
    ) u_vt_div (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clear(1'b0),
        .tick_in(hretrace_en),
        .tick_out(line_tick_half)
    );

    assign line_tick = mode_q[crtc_pkg::MC_VERTICAL_DOUBLE] ?
        line_tick_half : hretrace_en;

    assign frame_end = (scan_q == vertical_total);
    assign row_end = (row_q == max_scan_line);
    assign vbs_full = {vblank_start_ext, vbs_q};
    assign lcmp_full = {line_compare_ext, lcmp_q};
    assign split_hit = (scan_q == lcmp_full);
    assign scan_next = frame_end ? '0 : scan_q + VW'(1);
    assign v_active = (scan_q <= vertical_display_end);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scan_q <= '0;
            row_q <= '0;
        end else if (line_tick) begin
            scan_q <= scan_next;
            row_q <= (frame_end || row_end || split_hit) ? '0 :
                row_q + crtc_pkg::ROW_W'(1);
        end
    end

    // underline and vertical blank are decided per scan line
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            underline <= 1'b0;
            vblank <= 1'b0;
        end else begin
            underline <= (row_q == ul_mode_q[crtc_pkg::UL_LOC_LSB +: crtc_pkg::UL_LOC_W] +
                crtc_pkg::ROW_W'(1));
            // compare the line about to start, so blank lines up with the scan count
            if (line_tick && (scan_next == vbs_full + VW'(1))) begin
                vblank <= 1'b1;
            end else if (line_tick && (scan_next[7:0] == vbe_q)) begin
                vblank <= 1'b0;
            end
        end
    end

    // character clock dividers for the address counter, realigned each line
    pulse_divider #(
        .DIV(crtc_pkg::STEP_DIV_WORD)
    ) u_ma_div2 (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clear(hretrace_en),
        .tick_in(char_clk_en),
        .tick_out(step_half)
    );

    pulse_divider #(
        .DIV(crtc_pkg::STEP_DIV_FOUR)
    ) u_ma_div4 (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clear(hretrace_en),
        .tick_in(char_clk_en),
        .tick_out(step_four)
    );

    always_comb begin
        if (ul_mode_q[crtc_pkg::UL_COUNT_BY_FOUR]) begin
            ma_step = step_four;
        end else if (mode_q[crtc_pkg::MC_WORD_MODE_COUNT]) begin
            ma_step = step_half;
        end else begin
            ma_step = char_clk_en;
        end
    end

    // row pitch in counter units: x2 word, x4 doubleword, x8 quadword
    always_comb begin
        if (quadword_select) begin
            pitch = AW'({logical_line_width, 3'b000});
        end else if (ul_mode_q[crtc_pkg::UL_DOUBLEWORD_SELECT]) begin
            pitch = AW'({logical_line_width, 2'b00});
        end else begin
            pitch = AW'({logical_line_width, 1'b0});
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            row_start_q <= '0;
            ma_q <= '0;
        end else if (line_tick) begin
            if (frame_end) begin
                row_start_q <= display_start_addr;
                ma_q <= display_start_addr;
            end else if (split_hit) begin
                row_start_q <= '0;
                ma_q <= '0;
            end else if (row_end) begin
                row_start_q <= row_start_q + pitch;
                ma_q <= row_start_q + pitch;
            end else begin
                ma_q <= row_start_q;
            end
        end else if (ma_step && h_display && v_active) begin
            ma_q <= ma_q + AW'(1);
        end
    end

    // address output mapping, then bank substitution during display
    always_comb begin
        if (ul_mode_q[crtc_pkg::UL_DOUBLEWORD_SELECT]) begin
            addr_d = {ma_q[AW-3:0], ma_q[AW-1:AW-2]};
        end else if (!mode_q[crtc_pkg::MC_BYTE_MODE]) begin
            addr_d = {ma_q[AW-2:0], mode_q[crtc_pkg::MC_ADDRESS_WRAP_SELECT] ?
                ma_q[15] : ma_q[13]};
        end else begin
            addr_d = ma_q;
        end
        if (h_display && v_active) begin
            if (!mode_q[crtc_pkg::MC_BANK_TWO_SELECT]) begin
                addr_d[13] = row_q[0];
            end
            if (!mode_q[crtc_pkg::MC_BANK_FOUR_SELECT]) begin
                addr_d[14] = row_q[1];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr <= '0;
        end else begin
            mem_addr <= addr_d;
        end
    end

    // gating only; the counters keep running so re-enable is seamless
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
        end else begin
            hsync_out <= hsync_in && mode_q[crtc_pkg::MC_RETRACE_ENABLE];
            vsync_out <= vsync_in && mode_q[crtc_pkg::MC_RETRACE_ENABLE];
        end
    end
endmodule

// File: crtc_vaddr_checker_props.sv
`timescale 1ns/1ps
module crtc_vaddr_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // host port
    input wire logic io_sel,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // readback sources
    input wire logic [31:0] gc_cpu_latch,
    input wire logic [1:0] read_plane_select,
    input wire logic [4:0] attr_index,
    input wire logic video_display_enable,
    input wire logic attr_address_flipflop,
    // retrace
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic hsync_out,
    input wire logic vsync_out
);
    logic [7:0] idx_q;
    logic retrace_q;
    logic [31:0] latch_shift;
    logic [7:0] attr_word;
    assign latch_shift = gc_cpu_latch >> {read_plane_select, 3'b000};
    assign attr_word = {~attr_address_flipflop, 1'b0, video_display_enable, attr_index};
    // shadow of the index and retrace bit, rebuilt from host writes only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idx_q <= 8'h00;
        end else if (io_wr && !io_sel) begin
            idx_q <= io_wdata;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            retrace_q <= 1'b0;
        end else if (io_wr && io_sel && idx_q == 8'h17) begin
            retrace_q <= io_wdata[7];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    sequence s_data_rd(logic [7:0] i);
        io_rd && io_sel && idx_q == i;
    endsequence
    a_index_readback: assert property (io_rd && !io_sel |=> io_rdata == $past(idx_q))
        else $error("index readback differs from last index written");
    a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    a_latch_select: assert property (s_data_rd(8'h22) |=> io_rdata == $past(latch_shift[7:0]))
        else $error("latch readback is not the selected latch");
    a_attr_primary: assert property (s_data_rd(8'h24) |=> io_rdata == $past(attr_word))
        else $error("attribute readback wrong at first index");
    a_attr_alternate: assert property (s_data_rd(8'h26) |=> io_rdata == $past(attr_word))
        else $error("attribute readback wrong at second index");
    a_underline_reserved: assert property (s_data_rd(8'h14) |=> !io_rdata[7])
        else $error("reserved bit 7 of underline register read as one");
    a_mode_reserved: assert property (s_data_rd(8'h17) |=> !io_rdata[4])
        else $error("reserved bit 4 of mode register read as one");
    a_retrace_held: assert property (!retrace_q |=> !hsync_out && !vsync_out)
        else $error("retrace pulse while retrace disabled");
    a_retrace_pass: assert property (retrace_q && hsync_in && vsync_in |=> hsync_out && vsync_out)
        else $error("retrace pulse lost while enabled");
endmodule
bind crtc_vertical_addr_control crtc_vaddr_checker crtc_vaddr_checker_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .gc_cpu_latch(gc_cpu_latch),
    .read_plane_select(read_plane_select), .attr_index(attr_index),
    .video_display_enable(video_display_enable), .attr_address_flipflop(attr_address_flipflop),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .hsync_out(hsync_out), .vsync_out(vsync_out)
);

// File: display_timing_model.sv
`timescale 1ns/1ps
module display_timing_model #(
    parameter int LINE = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // timing strobes toward the controller
    output logic char_clk_en,
    output logic hretrace_en,
    output logic h_display,
    output logic hsync_in,
    output logic vsync_in
);
    logic [3:0] pos_q;
    logic [2:0] line_q;
    // falling-edge update so the controller always samples settled strobes
    always @(negedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pos_q <= 4'h0;
            line_q <= 3'h0;
        end else begin
            pos_q <= (pos_q == 4'(LINE - 1)) ? 4'h0 : pos_q + 4'h1;
            line_q <= (pos_q == 4'(LINE - 1)) ? line_q + 3'h1 : line_q;
        end
    end
    assign char_clk_en = arst_n;
    assign hretrace_en = pos_q == 4'(LINE - 1);
    assign h_display = pos_q < 4'h5;
    assign hsync_in = pos_q >= 4'(LINE - 2);
    assign vsync_in = line_q == 3'h6;
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys, arst_n, io_sel, io_wr, io_rd, char_clk_en, hretrace_en, h_display;
    logic hsync_in, vsync_in, quadword_select, video_display_enable, attr_address_flipflop;
    logic underline, vblank, hsync_out, vsync_out, pv;
    logic [7:0] io_wdata, io_rdata, v, vb, ul, vr;
    logic [10:0] vertical_total, vertical_display_end;
    logic [4:0] max_scan_line, attr_index;
    logic [2:0] vblank_start_ext, line_compare_ext;
    logic [9:0] logical_line_width;
    logic [15:0] display_start_addr, mem_addr;
    logic [31:0] gc_cpu_latch;
    logic [1:0] read_plane_select;
    logic [7:0] idx [5] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    logic [7:0] msk [5] = '{8'h7F, 8'hFF, 8'hFF, 8'hEF, 8'hFF};
    int miscompares, comparisons;
    crtc_vertical_addr_control crtc_vertical_addr_control_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .char_clk_en(char_clk_en),
        .hretrace_en(hretrace_en), .h_display(h_display), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .vertical_total(vertical_total),
        .vertical_display_end(vertical_display_end), .max_scan_line(max_scan_line),
        .vblank_start_ext(vblank_start_ext), .line_compare_ext(line_compare_ext),
        .logical_line_width(logical_line_width), .quadword_select(quadword_select),
        .display_start_addr(display_start_addr), .gc_cpu_latch(gc_cpu_latch),
        .read_plane_select(read_plane_select), .attr_index(attr_index),
        .video_display_enable(video_display_enable),
        .attr_address_flipflop(attr_address_flipflop), .mem_addr(mem_addr),
        .underline(underline), .vblank(vblank), .hsync_out(hsync_out), .vsync_out(vsync_out)
    );
    display_timing_model display_timing_model_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .char_clk_en(char_clk_en),
        .hretrace_en(hretrace_en), .h_display(h_display), .hsync_in(hsync_in),
        .vsync_in(vsync_in)
    );
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // strobe lowered then one spare edge, so back-to-back calls never collide
    task automatic wr(input logic sel, input logic [7:0] d);
        io_sel = sel;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_sys);
        io_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic sel, output logic [7:0] d);
        io_sel = sel;
        io_rd = 1'b1;
        @(negedge clk_sys);
        io_rd = 1'b0;
        @(negedge clk_sys);
        d = io_rdata;
    endtask
    task automatic setr(input logic [7:0] i, input logic [7:0] d);
        wr(1'b0, i);
        wr(1'b1, d);
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] exp);
        logic [7:0] d;
        wr(1'b0, i);
        rd(1'b1, d);
        check("register", d, exp);
    endtask
    // address sampled on the third display character of the line where blank starts
    task automatic ma_chk(input logic [7:0] md, input logic [15:0] exp);
        setr(8'h17, md);
        repeat (2) @(posedge vblank);
        repeat (4) @(negedge clk_sys);
        check("mem_addr", mem_addr, exp);
    endtask
    // one sample per line at a fixed phase, 32 lines
    task automatic count_lines();
        vb = 8'h00;
        ul = 8'h00;
        vr = 8'h00;
        pv = vblank;
        repeat (32) begin
            repeat (8) @(negedge clk_sys);
            vb = vb + {7'h00, vblank};
            ul = ul + {7'h00, underline};
            vr = vr + {7'h00, vblank && !pv};
            pv = vblank;
        end
    endtask
    task automatic count_sync();
        v = 8'h00;
        repeat (16) begin
            @(negedge clk_sys);
            v = v + {7'h00, hsync_out};
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
    initial begin
        {arst_n, io_sel, io_wr, io_rd, io_wdata, quadword_select} = '0;
        {vblank_start_ext, line_compare_ext, logical_line_width, display_start_addr} = '0;
        vertical_total = 11'h007;
        vertical_display_end = 11'h005;
        max_scan_line = 5'h03;
        gc_cpu_latch = 32'h44332211;
        {read_plane_select, attr_index, video_display_enable, attr_address_flipflop} = '0;
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        rd_chk(8'h17, 8'h00);
        for (int i = 0; i < 5; i++) begin
            setr(idx[i], 8'hFF);
            rd_chk(idx[i], msk[i]);
            setr(idx[i], 8'h00);
            rd_chk(idx[i], 8'h00);
        end
        setr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        wr(1'b0, 8'h16);
        rd(1'b0, v);
        check("index", v, 8'h16);
        $display("test register access done");
        setr(8'h22, 8'hFF);
        for (int p = 0; p < 4; p++) begin
            read_plane_select = p[1:0];
            rd_chk(8'h22, 8'h11 * 8'(p + 1));
        end
        video_display_enable = 1'b1;
        attr_index = 5'h15;
        for (int a = 0; a < 2; a++) begin
            attr_address_flipflop = a[0];
            rd_chk(8'h24, {~a[0], 2'b01, 5'h15});
            rd_chk(8'h26, {~a[0], 2'b01, 5'h15});
        end
        $display("test readback done");
        setr(8'h15, 8'h5A);
        count_sync();
        check("hsync off", v, 8'h00);
        setr(8'h17, 8'h80);
        count_sync();
        check("hsync on", v, 8'h04);
        rd_chk(8'h15, 8'h5A);
        $display("test retrace done");
        vblank_start_ext = 3'h1;
        setr(8'h14, 8'h01);
        setr(8'h15, 8'h02);
        setr(8'h16, 8'h05);
        repeat (64) @(negedge clk_sys);
        count_lines();
        check("vblank ext", vb, 8'h00);
        vblank_start_ext = 3'h0;
        repeat (64) @(negedge clk_sys);
        count_lines();
        check("vblank", vb, 8'h08);
        check("vblank rises", vr, 8'h04);
        check("underline", ul, 8'h08);
        setr(8'h17, 8'h84);
        count_lines();
        count_lines();
        check("vblank double", vb, 8'h08);
        check("vblank double rises", vr, 8'h02);
        $display("test vertical timing done");
        setr(8'h18, 8'hFF);
        display_start_addr = 16'h1000;
        logical_line_width = 10'h004;
        ma_chk(8'hC3, 16'h1002);
        ma_chk(8'hC2, 16'h3002);
        ma_chk(8'hC1, 16'h5002);
        ma_chk(8'hCB, 16'h1001);
        setr(8'h14, 8'h21);
        ma_chk(8'hC3, 16'h1000);
        setr(8'h14, 8'h41);
        display_start_addr = 16'h3000;
        ma_chk(8'hC3, 16'hC008);
        setr(8'h14, 8'h01);
        ma_chk(8'h83, 16'h6005);
        ma_chk(8'hA3, 16'h6004);
        setr(8'h18, 8'h02);
        ma_chk(8'hC3, 16'h0002);
        setr(8'h18, 8'hFF);
        setr(8'h15, 8'h03);
        display_start_addr = 16'h1000;
        ma_chk(8'hC3, 16'h100A);
        quadword_select = 1'b1;
        ma_chk(8'hC3, 16'h1022);
        $display("test address path done");
        print_verdict();
    end
endmodule
